// >>> oms_pkg.sv
package oms_pkg;

  // ------------------------------------------------------------
  // Clock and time figures
  // ------------------------------------------------------------
  localparam int CLK_NS = 4;
  localparam int T_REJECT_NS = 4500;
  localparam int T_RESET_NS = 10000;
  localparam int T_TICK_NS = 500000;
  localparam int T_WR_NS = 13000000;
  localparam int T_INIT_NS = 300000000;
  localparam int T_INIT2_NS = 200000000;
  localparam int T_DATA_NS = 400000000;
  localparam int T_TO_NS = 30000000;

  // Least times round up, longest times round down
  localparam int FILT_CYC = T_REJECT_NS / CLK_NS + 1;
  localparam int RESET_CYC = (T_RESET_NS + CLK_NS - 1) / CLK_NS;
  localparam int TICK_CYC = T_TICK_NS / CLK_NS;
  localparam int WR_CYC = T_WR_NS / CLK_NS;
  localparam int INIT_CYC = T_INIT_NS / CLK_NS;
  localparam int LOOP_CYC = T_INIT2_NS / CLK_NS;
  localparam int DATA_CYC = T_DATA_NS / CLK_NS;
  localparam int TO_CYC = T_TO_NS / CLK_NS;

  // ------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_MASKINT = 8'h08;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h0c;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h10;

  localparam int CTRL_SOFT_OFF = 0;
  localparam int CTRL_RATE_OUT = 1;
  localparam int CTRL_SOFT_FAULT = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [7:0] MASKINT_RST = 8'h04;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;
  localparam logic [6:0] DEV_ADDR_DEF = 7'h50;

  // ------------------------------------------------------------
  // Carriers and states
  // ------------------------------------------------------------
  typedef struct packed {
    logic laser_on;
    logic nvm_busy;
    logic data_ready;
    logic loop_on;
    logic rate_in;
    logic rx_lost;
    logic tx_off;
    logic tx_fault;
  } oms_status_t;

  typedef struct packed {
    logic bus_to;
    logic nvm_done;
    logic los_chg;
    logic fault;
  } oms_irq_t;

  typedef enum logic [3:0] {
    SUP_INIT = 4'b0001,
    SUP_RUN = 4'b0010,
    SUP_FAULT = 4'b0100,
    SUP_OFF = 4'b1000
  } oms_sup_t;

  typedef enum logic [3:0] {
    SER_IDLE = 4'b0001,
    SER_RECV = 4'b0010,
    SER_ACK = 4'b0100,
    SER_SKIP = 4'b1000
  } oms_ser_t;

endpackage : oms_pkg

// >>> oms_filter.sv
`timescale 1ns/1ns
module oms_filter #(
  parameter int STABLE = 1,
  parameter int W = 11
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic raw_i,
  output logic out_o
);
  import oms_pkg::*;

  logic meta_r;
  logic sync_r;
  logic [W-1:0] cnt_r;

  // Two flops before anything looks at the pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else if (ce_i) begin
      meta_r <= raw_i;
      sync_r <= meta_r;
    end
  end

  // Output follows only after STABLE equal samples
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= '0;
      out_o <= 1'b0;
    end else if (ce_i) begin
      if (sync_r == out_o) begin
        cnt_r <= '0;
      end else if (cnt_r >= W'(STABLE - 1)) begin
        cnt_r <= '0;
        out_o <= sync_r;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

endmodule : oms_filter

// >>> oms_timer.sv
`timescale 1ns/1ns
module oms_timer #(
  parameter int W = 27
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic start_i,
  input wire logic clear_i,
  input wire logic [W-1:0] load_i,
  output logic busy_o,
  output logic done_o
);
  import oms_pkg::*;

  logic [W-1:0] cnt_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else if (ce_i) begin
      done_o <= 1'b0;
      if (clear_i) begin
        busy_o <= 1'b0;
        cnt_r <= '0;
      end else if (start_i) begin
        busy_o <= 1'b1;
        cnt_r <= load_i;
      end else if (busy_o) begin
        if (cnt_r <= W'(1)) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

endmodule : oms_timer

// >>> oms_supervisor.sv
`timescale 1ns/1ns
module oms_supervisor #(
  parameter int unsigned TICK_N = oms_pkg::TICK_CYC,
  parameter int unsigned WR_N = oms_pkg::WR_CYC,
  parameter int unsigned INIT_N = oms_pkg::INIT_CYC,
  parameter int unsigned LOOP_N = oms_pkg::LOOP_CYC,
  parameter int unsigned DATA_N = oms_pkg::DATA_CYC,
  parameter int unsigned TO_N = oms_pkg::TO_CYC,
  parameter logic [6:0] DEV_ADDR = oms_pkg::DEV_ADDR_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic tx_off_request_i,
  input wire logic tx_fault_cmp_i,
  input wire logic rx_loss_cmp_i,
  input wire logic rate_select_in_i,
  output logic tx_fault_out_o,
  output logic rate_select_out_o,
  output logic rx_signal_lost_o,
  output logic laser_drive_on_o,
  output logic auto_laser_power_loop_o,
  output logic int_o,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o
);
  import oms_pkg::*;

  localparam int CW = 27;
  localparam int NIN = 6;

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr[7:2] == off[7:2]);
  endfunction : hit

  // ------------------------------------------------------------
  // Input conditioning
  // ------------------------------------------------------------
  logic [NIN-1:0] raw;
  logic [NIN-1:0] flt;
  assign raw = {sda_i, scl_i, rate_select_in_i, tx_off_request_i, rx_loss_cmp_i, tx_fault_cmp_i};

  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_in
      // Comparators get the long filter, plain pins a bare sync
      oms_filter #(
        .STABLE((gi < 2) ? FILT_CYC : 1),
        .W(11)
      ) u_flt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .raw_i(raw[gi]),
        .out_o(flt[gi])
      );
    end
  endgenerate

  logic fault_f;
  logic los_f;
  logic off_pin;
  logic rate_in;
  logic scl_s;
  logic sda_s;
  assign fault_f = flt[0];
  assign los_f = flt[1];
  assign off_pin = flt[2];
  assign rate_in = flt[3];
  assign scl_s = flt[4];
  assign sda_s = flt[5];

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [2:0] ctrl_r;
  logic [7:0] maskint_r;
  oms_irq_t irq_stat_r;
  oms_irq_t irq_mask_r;
  oms_irq_t irq_set;
  oms_status_t status;
  logic wb_req;
  logic wb_wr;

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr = wb_req & wb_we_i & wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else if (ce_i) begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0;
      if (wb_req && !wb_we_i) begin
        if (hit(wb_adr_i, ADR_CTRL)) wb_dat_o[2:0] <= ctrl_r;
        if (hit(wb_adr_i, ADR_STATUS)) wb_dat_o[7:0] <= status;
        if (hit(wb_adr_i, ADR_MASKINT)) wb_dat_o[7:0] <= maskint_r;
        if (hit(wb_adr_i, ADR_IRQ_STAT)) wb_dat_o[3:0] <= irq_stat_r;
        if (hit(wb_adr_i, ADR_IRQ_MASK)) wb_dat_o[3:0] <= irq_mask_r;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= CTRL_RST;
      maskint_r <= MASKINT_RST;
      irq_mask_r <= IRQ_MASK_RST;
    end else if (ce_i && wb_wr) begin
      if (hit(wb_adr_i, ADR_CTRL)) ctrl_r <= wb_dat_i[2:0];
      if (hit(wb_adr_i, ADR_MASKINT)) maskint_r <= wb_dat_i[7:0];
      if (hit(wb_adr_i, ADR_IRQ_MASK)) irq_mask_r <= wb_dat_i[3:0];
    end
  end

  // Set wins over a write-one-to-clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_r <= '0;
    end else if (ce_i) begin
      if (wb_wr && hit(wb_adr_i, ADR_IRQ_STAT)) begin
        irq_stat_r <= (irq_stat_r & ~wb_dat_i[3:0]) | irq_set;
      end else begin
        irq_stat_r <= irq_stat_r | irq_set;
      end
    end
  end

  // ------------------------------------------------------------
  // Power-on deadlines
  // ------------------------------------------------------------
  logic [CW-1:0] pwr_cnt_r;
  logic loop_on_r;
  logic data_ready_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_cnt_r <= '0;
      loop_on_r <= 1'b0;
      data_ready_r <= 1'b0;
    end else if (ce_i) begin
      if (!data_ready_r) pwr_cnt_r <= pwr_cnt_r + 1'b1;
      if (pwr_cnt_r >= CW'(LOOP_N - 1)) loop_on_r <= 1'b1;
      if (pwr_cnt_r >= CW'(DATA_N - 1)) data_ready_r <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Transmitter supervisor
  // ------------------------------------------------------------
  oms_sup_t sup_r;
  logic tx_off;
  logic init_kick_r;
  logic init_done;
  logic hold_done;
  logic hold_busy;
  logic [CW-1:0] tick_cnt_r;
  logic [7:0] mask_ticks_r;

  assign tx_off = off_pin | ctrl_r[CTRL_SOFT_OFF];

  oms_timer #(.W(CW)) u_init (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .start_i(init_kick_r),
    .clear_i(tx_off),
    .load_i(CW'(INIT_N)),
    .busy_o(),
    .done_o(init_done)
  );

  // Restarted on every rise, so a short request never completes
  oms_timer #(.W(CW)) u_hold (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .start_i(tx_off & (sup_r == SUP_FAULT) & ~hold_busy),
    .clear_i(~tx_off),
    .load_i(CW'(RESET_CYC)),
    .busy_o(hold_busy),
    .done_o(hold_done)
  );

  // Mask interval ticks, counted only during initialisation
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt_r <= '0;
      mask_ticks_r <= 8'h0;
    end else if (ce_i) begin
      if (sup_r != SUP_INIT) begin
        tick_cnt_r <= '0;
        mask_ticks_r <= 8'h0;
      end else if (tick_cnt_r >= CW'(TICK_N - 1)) begin
        tick_cnt_r <= '0;
        if (mask_ticks_r != 8'hff) mask_ticks_r <= mask_ticks_r + 8'h1;
      end else begin
        tick_cnt_r <= tick_cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sup_r <= SUP_INIT;
      init_kick_r <= 1'b1;
    end else if (ce_i) begin
      init_kick_r <= 1'b0;
      case (sup_r)
        SUP_INIT: begin
          if (tx_off) sup_r <= SUP_OFF;
          else if (mask_ticks_r >= maskint_r || init_done) sup_r <= SUP_RUN;
        end
        SUP_RUN: begin
          if (tx_off) sup_r <= SUP_OFF;
          else if (fault_f) sup_r <= SUP_FAULT;
        end
        SUP_FAULT: begin
          if (hold_done) sup_r <= SUP_OFF;
        end
        SUP_OFF: begin
          if (!tx_off) begin
            sup_r <= SUP_INIT;
            init_kick_r <= 1'b1;
          end
        end
        default: sup_r <= SUP_INIT;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Serial slave
  // ------------------------------------------------------------
  oms_ser_t ser_r;
  logic scl_q_r;
  logic sda_q_r;
  logic [7:0] shift_r;
  logic [3:0] bit_r;
  logic addr_ph_r;
  logic acked_r;
  logic [2:0] nbytes_r;
  logic [CW-1:0] to_cnt_r;
  logic nvm_busy;
  logic nvm_done;
  logic nvm_start;
  logic ser_to;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;

  assign scl_rise = scl_s & ~scl_q_r;
  assign scl_fall = ~scl_s & scl_q_r;
  assign start_c = scl_s & scl_q_r & sda_q_r & ~sda_s;
  assign stop_c = scl_s & scl_q_r & ~sda_q_r & sda_s;
  assign nvm_start = stop_c & (ser_r != SER_IDLE) & (nbytes_r != 3'h0);
  assign ser_to = (ser_r != SER_IDLE) && (to_cnt_r >= CW'(TO_N - 1));

  oms_timer #(.W(CW)) u_nvm (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .start_i(nvm_start),
    .clear_i(1'b0),
    .load_i(CW'(WR_N)),
    .busy_o(nvm_busy),
    .done_o(nvm_done)
  );

  // Clock held low mid transaction
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      to_cnt_r <= '0;
    end else if (ce_i) begin
      if (ser_r == SER_IDLE || scl_s) to_cnt_r <= '0;
      else to_cnt_r <= to_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      ser_r <= SER_IDLE;
      shift_r <= 8'h0;
      bit_r <= 4'h0;
      addr_ph_r <= 1'b0;
      acked_r <= 1'b0;
      nbytes_r <= 3'h0;
      sda_oe_o <= 1'b0;
    end else if (ce_i) begin
      scl_q_r <= scl_s;
      sda_q_r <= sda_s;
      if (ser_to || stop_c) begin
        ser_r <= SER_IDLE;
        sda_oe_o <= 1'b0;
        nbytes_r <= 3'h0;
      end else if (start_c) begin
        ser_r <= SER_RECV;
        bit_r <= 4'h0;
        addr_ph_r <= 1'b1;
        nbytes_r <= 3'h0;
        sda_oe_o <= 1'b0;
      end else begin
        case (ser_r)
          SER_IDLE: sda_oe_o <= 1'b0;
          SER_RECV: begin
            if (scl_rise) begin
              shift_r <= {shift_r[6:0], sda_s};
              bit_r <= bit_r + 4'h1;
            end
            if (scl_fall && bit_r == 4'h8) begin
              acked_r <= addr_ph_r ? (shift_r[7:1] == DEV_ADDR && !shift_r[0] && !nvm_busy) : 1'b1;
              sda_oe_o <= addr_ph_r ? (shift_r[7:1] == DEV_ADDR && !shift_r[0] && !nvm_busy) : 1'b1;
              if (!addr_ph_r && nbytes_r != 3'h7) nbytes_r <= nbytes_r + 3'h1;
              ser_r <= SER_ACK;
            end
          end
          SER_ACK: begin
            if (scl_fall) begin
              sda_oe_o <= 1'b0;
              bit_r <= 4'h0;
              addr_ph_r <= 1'b0;
              ser_r <= acked_r ? SER_RECV : SER_SKIP;
            end
          end
          SER_SKIP: sda_oe_o <= 1'b0;
          default: ser_r <= SER_IDLE;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Events and pins
  // ------------------------------------------------------------
  logic los_q_r;
  logic to_q_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      los_q_r <= 1'b0;
      to_q_r <= 1'b0;
    end else if (ce_i) begin
      los_q_r <= los_f;
      to_q_r <= ser_to;
    end
  end

  always_comb begin
    irq_set = '0;
    irq_set.fault = (sup_r == SUP_RUN) & fault_f & ~tx_off;
    irq_set.los_chg = los_f ^ los_q_r;
    irq_set.nvm_done = nvm_done;
    irq_set.bus_to = ser_to & ~to_q_r;
  end

  always_comb begin
    status = '0;
    status.laser_on = laser_drive_on_o;
    status.nvm_busy = nvm_busy;
    status.data_ready = data_ready_r;
    status.loop_on = loop_on_r;
    status.rate_in = rate_in;
    status.rx_lost = los_f;
    status.tx_off = off_pin;
    status.tx_fault = tx_fault_out_o;
  end

  // Fault pin stays up through init, so the host sees no false ready
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_fault_out_o <= 1'b1;
      rate_select_out_o <= 1'b0;
      rx_signal_lost_o <= 1'b0;
      laser_drive_on_o <= 1'b0;
      auto_laser_power_loop_o <= 1'b0;
      int_o <= 1'b0;
      sda_o <= 1'b0;
    end else if (ce_i) begin
      tx_fault_out_o <= (sup_r == SUP_INIT) | (sup_r == SUP_FAULT) | ctrl_r[CTRL_SOFT_FAULT];
      rate_select_out_o <= ctrl_r[CTRL_RATE_OUT];
      rx_signal_lost_o <= los_f;
      laser_drive_on_o <= ((sup_r == SUP_INIT) | (sup_r == SUP_RUN)) & ~tx_off;
      auto_laser_power_loop_o <= loop_on_r;
      int_o <= |(irq_stat_r & irq_mask_r);
      sda_o <= 1'b0;
    end
  end

endmodule : oms_supervisor

// >>> oms_monitor.sv
`timescale 1ns/1ns
module oms_monitor #(
  parameter int unsigned TO_N = 500
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic tx_off_request_i,
  input wire logic tx_fault_cmp_i,
  input wire logic rx_loss_cmp_i,
  input wire logic scl_i,
  input wire logic tx_fault_out_o,
  input wire logic rate_select_out_o,
  input wire logic rx_signal_lost_o,
  input wire logic laser_drive_on_o,
  input wire logic sda_oe_o
);
  // ----
  // Run lengths
  // ----
  // Saturate so a long quiet spell never wraps back under a bound
  logic [11:0] flt_r;
  logic [11:0] los_r;
  logic [11:0] off_r;
  logic [15:0] scl_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flt_r <= 12'h0;
      los_r <= 12'h0;
      off_r <= 12'h0;
      scl_r <= 16'h0;
    end else begin
      flt_r <= $changed(tx_fault_cmp_i) ? 12'h0 : flt_r + {11'h0, ~&flt_r};
      los_r <= $changed(rx_loss_cmp_i) ? 12'h0 : los_r + {11'h0, ~&los_r};
      off_r <= tx_off_request_i ? off_r + {11'h0, ~&off_r} : 12'h0;
      scl_r <= scl_i ? 16'h0 : scl_r + {15'h0, ~&scl_r};
    end
  end
  default clocking mcb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----
  // Checks
  // ----
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than a cycle");
  ack_next_cycle_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack missing");
  idle_data_zero_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
  rate_after_write_a:
    assert property ($changed(rate_select_out_o) |-> $past(wb_ack_o) || $past(wb_ack_o, 2) || $past(wb_ack_o, 3))
      else $error("rate output moved without a write");
  laser_off_a:
    assert property ($rose(tx_off_request_i) |-> ##[1:20] !laser_drive_on_o) else $error("laser drive still on");
  fault_clear_hold_a:
    assert property ($fell(tx_fault_out_o) && !laser_drive_on_o |-> off_r >= 12'h9c4)
      else $error("fault cleared by a short off request");
  glitch_reject_a:
    assert property ($rose(tx_fault_out_o) ##2 !laser_drive_on_o |-> $past(flt_r, 2) >= 12'h466)
      else $error("fault latched on a short pulse");
  loss_filter_a:
    assert property ($changed(rx_signal_lost_o) |-> los_r >= 12'h466) else $error("loss output moved on a glitch");
  bus_timeout_a:
    assert property (scl_r >= TO_N + 8 |-> !sda_oe_o) else $error("data line held past bus timeout");
endmodule : oms_monitor

bind oms_supervisor oms_monitor #(.TO_N(TO_N)) u_mon (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .tx_off_request_i, .tx_fault_cmp_i,
  .rx_loss_cmp_i, .scl_i, .tx_fault_out_o, .rate_select_out_o, .rx_signal_lost_o, .laser_drive_on_o, .sda_oe_o
);

// >>> oms_host_model.sv
`timescale 1ns/1ns
module oms_host_model (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  // ----
  // Bus phases
  // ----
  // One phase is 40 ns, a third of the 120 ns bit period; clock stands high when idle
  task automatic ph(input logic c, input logic o);
    scl_o <= c;
    sda_oe_o <= o;
    repeat (10) @(posedge clk_i);
  endtask : ph
  // Data moves only while the clock is low, so no false start or stop
  task automatic xfer(input logic [7:0] b, input logic st, input int hold, output logic ack);
    if (st) begin
      ph(1'b1, 1'b1);
      ph(1'b0, 1'b1);
    end
    for (int i = 7; i >= 0; i--) begin
      ph(1'b0, !b[i]);
      ph(1'b1, !b[i]);
      ph(1'b0, !b[i]);
    end
    ph(1'b0, 1'b0);
    repeat (hold) ph(1'b0, 1'b0);
    ph(1'b1, 1'b0);
    ack = sda_i;
    ph(1'b0, 1'b0);
  endtask : xfer
  task automatic stop;
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
  endtask : stop
endmodule : oms_host_model

// >>> test_optic_module_supervisor_timing.sv
`timescale 1ns/1ns
module test_optic_module_supervisor_timing;
  import oms_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h0;
  logic [3:0] sel = 4'hf;
  logic [3:0] wsel = 4'hf;
  logic [31:0] wdat = 32'h0;
  logic tx_off = 1'b0;
  logic flt_cmp = 1'b0;
  logic los_cmp = 1'b0;
  logic rate_in = 1'b0;
  logic ce = 1'b1;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack, fault_o, rate_o, lost_o, laser_o, loop_o, irq_o, scl, sda_w, d_oe, h_oe, b;
  int n;
  int error_cnt = 0;
  int checks = 0;
  always #2 clk = ~clk;
  // Pull-up: a released line reads high
  assign sda_w = !(d_oe || h_oe);
  // Init always ends on mask ticks here, so the long init deadline keeps its default
  oms_supervisor #(.TICK_N(20), .WR_N(1000), .LOOP_N(300), .DATA_N(600), .TO_N(500)) u_dut (
    .clk_i(clk), .rst_i(rst), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .tx_off_request_i(tx_off),
    .tx_fault_cmp_i(flt_cmp), .rx_loss_cmp_i(los_cmp), .rate_select_in_i(rate_in), .tx_fault_out_o(fault_o),
    .rate_select_out_o(rate_o), .rx_signal_lost_o(lost_o), .laser_drive_on_o(laser_o),
    .auto_laser_power_loop_o(loop_o), .int_o(irq_o), .scl_i(scl), .sda_i(sda_w), .sda_o(), .sda_oe_o(d_oe)
  );
  oms_host_model u_host (.clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_oe_o(h_oe));
  // ----
  // Tasks
  // ----
  task automatic end_of_test;
    if (error_cnt == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= wsel;
    @(posedge clk);
    while (ack !== 1'b1) begin
      k++;
      if (k > 50) begin
        chk(0, 1, "no bus answer");
        end_of_test();
      end
      @(posedge clk);
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  // Index: 0 fault, 1 laser, 2 loss, 3 loop, 4 rate, 5 interrupt
  function automatic logic pin(input int i);
    case (i)
      0: return fault_o;
      1: return laser_o;
      2: return lost_o;
      3: return loop_o;
      4: return rate_o;
      default: return irq_o;
    endcase
  endfunction : pin
  task automatic wt(input int i, input logic v, input int lim);
    int k;
    k = 0;
    while (pin(i) !== v && k < lim) begin
      @(posedge clk);
      k++;
    end
    chk(pin(i), v, "pin late");
    if (pin(i) !== v)
      end_of_test();
  endtask : wt
  // ----
  // Sequence
  // ----
  initial begin
    repeat (5) @(posedge clk);
    chk(fault_o, 1, "fault low in reset");
    rst <= 1'b0;
    wt(3, 1, 310);
    wt(0, 0, 2010);
    chk(laser_o, 1, "laser off after init");
    wb(0, ADR_MASKINT, 0);
    chk(q, 32'h4, "mask interval reset");
    wb(0, ADR_IRQ_MASK, 0);
    chk(q, 32'h0, "irq mask reset");
    wb(1, 8'hfc, 32'hff);
    wb(0, 8'hfc, 0);
    chk(q, 32'h0, "unmapped read");
    repeat (600) @(posedge clk);
    wb(0, ADR_STATUS, 0);
    chk(q[5], 1, "data not ready");
    wsel = 4'h0;
    wb(1, ADR_CTRL, 32'h2);
    wsel = 4'hf;
    repeat (250) @(posedge clk);
    chk(rate_o, 0, "write without lane 0");
    wb(1, ADR_CTRL, 32'h2);
    wt(4, 1, 250);
    wb(1, ADR_CTRL, 32'h0);
    wt(4, 0, 250);
    wb(1, ADR_CTRL, 32'h4);
    wt(0, 1, 250);
    wb(1, ADR_CTRL, 32'h0);
    wt(0, 0, 250);
    rate_in <= 1'b1;
    repeat (250) @(posedge clk);
    wb(0, ADR_STATUS, 0);
    chk(q[3], 1, "rate input unseen");
    tx_off <= 1'b1;
    wt(1, 0, 2500);
    repeat (250) @(posedge clk);
    wb(0, ADR_STATUS, 0);
    chk(q[1], 1, "off pin unseen");
    tx_off <= 1'b0;
    wt(1, 1, 250000);
    wt(0, 0, 2010);
    wb(1, ADR_CTRL, 32'h1);
    wt(1, 0, 2500);
    wb(1, ADR_CTRL, 32'h0);
    wt(1, 1, 250000);
    wt(0, 0, 2010);
    wb(1, ADR_IRQ_MASK, 32'h1);
    flt_cmp <= 1'b1;
    repeat (1100) @(posedge clk);
    flt_cmp <= 1'b0;
    repeat (1500) @(posedge clk);
    chk(fault_o, 0, "glitch latched");
    flt_cmp <= 1'b1;
    wt(0, 1, 23750);
    flt_cmp <= 1'b0;
    wt(5, 1, 250);
    wb(1, ADR_IRQ_MASK, 32'h0);
    wt(5, 0, 250);
    wb(0, ADR_IRQ_STAT, 0);
    chk(q, 32'h1, "fault event lost");
    wb(1, ADR_IRQ_STAT, 32'h1);
    wb(1, ADR_IRQ_MASK, 32'h1);
    repeat (5) @(posedge clk);
    chk(irq_o, 0, "event not cleared");
    tx_off <= 1'b1;
    repeat (2000) @(posedge clk);
    tx_off <= 1'b0;
    repeat (100) @(posedge clk);
    chk(fault_o, 1, "short off cleared fault");
    tx_off <= 1'b1;
    repeat (2600) @(posedge clk);
    chk(fault_o, 0, "long off kept fault");
    tx_off <= 1'b0;
    wt(1, 1, 250000);
    wt(0, 0, 2010);
    // Enable low must freeze the loss filter
    ce <= 1'b0;
    los_cmp <= 1'b1;
    repeat (1500) @(posedge clk);
    chk(lost_o, 0, "loss moved with enable low");
    ce <= 1'b1;
    wt(2, 1, 23750);
    los_cmp <= 1'b0;
    wt(2, 0, 25000);
    wb(1, ADR_IRQ_STAT, 32'hf);
    u_host.xfer({DEV_ADDR_DEF, 1'b0}, 1'b1, 0, b);
    chk(b, 0, "address not acked");
    u_host.xfer(8'h5a, 1'b0, 0, b);
    chk(b, 0, "data not acked");
    u_host.stop();
    n = 0;
    do begin
      u_host.xfer({DEV_ADDR_DEF, 1'b0}, 1'b1, 0, b);
      u_host.stop();
      n++;
    end while (b !== 1'b0 && n < 6);
    chk(n > 1, 1, "acked while writing");
    chk(b, 0, "write cycle too long");
    u_host.xfer({DEV_ADDR_DEF, 1'b0}, 1'b1, 60, b);
    chk(b, 1, "ack survived stall");
    chk(d_oe, 0, "line held after stall");
    u_host.stop();
    wb(0, ADR_IRQ_STAT, 0);
    chk(q, 32'hc, "write and timeout events");
    end_of_test();
  end
endmodule : test_optic_module_supervisor_timing
